// ===== uart_line_format_pkg.sv
package uart_line_format_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_DATA      = 4'h0;  // Holding data / divisor low byte
  localparam logic [3:0] OFS_DIV_HIGH  = 4'h1;  // Divisor high byte
  localparam logic [3:0] OFS_FIFO_CTRL = 4'h2;  // fifo_setup_control (write), ident (read)
  localparam logic [3:0] OFS_LINE_FMT  = 4'h3;  // line_format_control
  localparam logic [3:0] OFS_LINE_STAT = 4'h5;  // Line status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FIFO_EN_BIT  = 0;
  localparam int RX_CLR_BIT   = 1;
  localparam int TX_CLR_BIT   = 2;
  localparam int WLEN_LSB     = 0;
  localparam int STOP_BIT     = 2;
  localparam int PAR_EN_BIT   = 3;
  localparam int PAR_EVEN_BIT = 4;
  localparam int PAR_SET_BIT  = 5;
  localparam int BREAK_BIT    = 6;
  localparam int DIV_EN_BIT   = 7;

  // ----------------------------------------------------------------
  // Reset values and special codes
  // ----------------------------------------------------------------
  localparam logic [7:0] LINE_FMT_RST  = 8'h00;
  localparam logic [7:0] ENHANCED_CODE = 8'hbf;
  localparam logic [7:0] DIV_LOW_RST   = 8'h01;
  localparam logic [7:0] DIV_HIGH_RST  = 8'h00;
  localparam logic [5:0] IDENT_LOW     = 6'h01;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [2:0] MIN_WLEN       = 3'h5;
  localparam logic [5:0] TICKS_BIT      = 6'h10;  // Oversampling per bit
  localparam logic [5:0] TICKS_HALF     = 6'h08;
  localparam logic [5:0] TICKS_STOP_1H  = 6'h18;  // One and a half stop bits
  localparam logic [5:0] TICKS_STOP_2   = 6'h20;
  localparam logic [1:0] CLR_XTAL_EDGES = 2'h2;

endpackage : uart_line_format_pkg

// ===== uart_line_format_control.sv
// Behaviour
// R01 - Both FIFOs stay disabled while the FIFO enable bit is 0 (its reset value) and work together once it is 1.
// R02 - A FIFO clear completes only after two rising edges of the crystal reference clock.
// R03 - Divisor latch enable at bit 7 of line_format_control resets to 0 and opens divisor access at 1.
// R04 - While break bit 6 is 1 the serial output is held at 0 until software clears the bit.
// R05 - Parity enable bit 3 adds a parity bit on transmit and checks it on receive; at 0 none is used.
// R06 - With parity on and not forced, bit 4 at 0 gives odd parity and at 1 even parity, both ways.
// R07 - With parity on and bit 5 at 1 the parity bit is the constant inverse of bit 4, both ways.
// R08 - Stop bit select at bit 2 gives one stop bit at 0, and at 1 one and a half for 5-bit words, else two.
// R09 - Word length bits 00..11 give 5..8 data bits for transmit and receive.
// R10 - A FIFO reset bit empties that FIFO and its level without touching the shift register, then drops.
// R11 - Divisor bytes are reachable only with bit 7 set and line_format_control not at the enhanced code.
`timescale 1ns/100ps
module uart_line_format_control #(
  parameter int DEPTH = 64
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       xtalRef,
  input  wire logic [3:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       rxIn,
  output logic            txOut
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_C   = CW'(1);

  typedef enum logic [2:0] {IDLE, START, DATA, PARITY, STOP} ser_e;

  typedef struct packed {
    logic [7:0]                lineFmt;
    logic                      fifoEn;
    logic [7:0]                divLow;
    logic [7:0]                divHigh;
    logic [DEPTH-1:0][7:0]     txMem;
    logic [PW-1:0]             txWp;
    logic [PW-1:0]             txRp;
    logic [CW-1:0]             txCnt;
    logic [DEPTH-1:0][7:0]     rxMem;
    logic [PW-1:0]             rxWp;
    logic [PW-1:0]             rxRp;
    logic [CW-1:0]             rxCnt;
    logic                      txClr;
    logic                      rxClr;
    logic [1:0]                txEdges;
    logic [1:0]                rxEdges;
    logic                      xSync1;
    logic                      xSync2;
    logic                      xPrev;
    logic                      rSync1;
    logic                      rSync2;
    logic [15:0]               baudCnt;
    ser_e                      txState;
    logic [5:0]                txTick;
    logic [2:0]                txBit;
    logic [7:0]                txShift;
    logic                      txPar;
    logic                      txLine;
    ser_e                      rxState;
    logic [5:0]                rxTick;
    logic [2:0]                rxBit;
    logic [7:0]                rxShift;
    logic                      rxPar;
    logic                      parErr;
    logic                      frmErr;
    logic                      ovrErr;
    logic [7:0]                rdata;
  } state_s;

  state_s r;
  state_s n;

  // ------------------------------------------------------------------
  // Format decode
  // ------------------------------------------------------------------
  function automatic logic parity_bit(input logic [7:0] fmt, input logic [7:0] d);
    logic [7:0] m;
    m = d & ~(8'hff << (4'(uart_line_format_pkg::MIN_WLEN) + 4'(fmt[1:0])));  // R09
    if (fmt[uart_line_format_pkg::PAR_SET_BIT]) begin
      parity_bit = ~fmt[uart_line_format_pkg::PAR_EVEN_BIT];                // R07
    end else if (fmt[uart_line_format_pkg::PAR_EVEN_BIT]) begin
      parity_bit = ^m;                                                      // R06
    end else begin
      parity_bit = ~^m;                                                     // R06
    end
  endfunction : parity_bit

  logic       tick;
  logic [2:0] lastBit;
  logic [5:0] stopTicks;
  logic       divOpen;
  logic       xRise;
  logic       txPush;
  logic       txPop;
  logic       rxPush;
  logic       rxPop;
  logic [CW-1:0] cap;
  logic [7:0] rxWord;

  always_comb begin
    n         = r;
    tick      = (r.baudCnt == 16'h0000);
    lastBit   = 3'(uart_line_format_pkg::MIN_WLEN + 3'(r.lineFmt[1:0]) - 3'h1);  // R09
    divOpen   = r.lineFmt[uart_line_format_pkg::DIV_EN_BIT]
                && (r.lineFmt != uart_line_format_pkg::ENHANCED_CODE);           // R11
    if (!r.lineFmt[uart_line_format_pkg::STOP_BIT]) begin
      stopTicks = uart_line_format_pkg::TICKS_BIT;                               // R08
    end else if (r.lineFmt[1:0] == 2'b00) begin
      stopTicks = uart_line_format_pkg::TICKS_STOP_1H;                           // R08
    end else begin
      stopTicks = uart_line_format_pkg::TICKS_STOP_2;                            // R08
    end
    cap       = r.fifoEn ? DEPTH_C : ONE_C;                                      // R01
    txPush    = 1'b0;
    txPop     = 1'b0;
    rxPush    = 1'b0;
    rxPop     = 1'b0;
    rxWord    = r.rxShift >> (3'h7 - lastBit);

    // ----------------------------------------------------------------
    // Synchronisers and baud tick
    // ----------------------------------------------------------------
    n.xSync1  = xtalRef;
    n.xSync2  = r.xSync1;
    n.xPrev   = r.xSync2;
    xRise     = r.xSync2 && !r.xPrev;
    n.rSync1  = rxIn;
    n.rSync2  = r.rSync1;
    n.baudCnt = tick ? ({r.divHigh, r.divLow} - 16'h0001) : (r.baudCnt - 16'h0001);
    if (tick && {r.divHigh, r.divLow} == 16'h0000) begin
      n.baudCnt = 16'h0000;
    end

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    if (regWrite) begin
      case (regAddr)
        uart_line_format_pkg::OFS_DATA: begin
          if (divOpen) begin
            n.divLow = regWdata;                                                 // R11
          end else if (!r.lineFmt[uart_line_format_pkg::DIV_EN_BIT]) begin
            txPush = (r.txCnt < cap);
          end
        end
        uart_line_format_pkg::OFS_DIV_HIGH: begin
          if (divOpen) begin
            n.divHigh = regWdata;                                                // R11
          end
        end
        uart_line_format_pkg::OFS_FIFO_CTRL: begin
          n.fifoEn = regWdata[uart_line_format_pkg::FIFO_EN_BIT];                // R01
          if (regWdata[uart_line_format_pkg::TX_CLR_BIT]) begin
            n.txClr   = 1'b1;                                                    // R10
            n.txEdges = 2'h0;
          end
          if (regWdata[uart_line_format_pkg::RX_CLR_BIT]) begin
            n.rxClr   = 1'b1;                                                    // R10
            n.rxEdges = 2'h0;
          end
        end
        uart_line_format_pkg::OFS_LINE_FMT: n.lineFmt = regWdata;                // R03
        default: ;
      endcase
    end
    if (regRead) begin
      case (regAddr)
        uart_line_format_pkg::OFS_DATA: begin
          if (divOpen) begin
            n.rdata = r.divLow;
          end else if (!r.lineFmt[uart_line_format_pkg::DIV_EN_BIT]) begin
            n.rdata = r.rxMem[r.rxRp];
            rxPop   = (r.rxCnt != '0);
          end else begin
            n.rdata = 8'h00;
          end
        end
        uart_line_format_pkg::OFS_DIV_HIGH:  n.rdata = divOpen ? r.divHigh : 8'h00;
        uart_line_format_pkg::OFS_FIFO_CTRL:
          n.rdata = {r.fifoEn, r.fifoEn, uart_line_format_pkg::IDENT_LOW};
        uart_line_format_pkg::OFS_LINE_FMT:  n.rdata = r.lineFmt;
        uart_line_format_pkg::OFS_LINE_STAT: begin
          n.rdata  = {1'b0, (r.txCnt == '0) && (r.txState == IDLE), r.txCnt == '0,
                      1'b0, r.frmErr, r.parErr, r.ovrErr, r.rxCnt != '0};
          n.parErr = 1'b0;
          n.frmErr = 1'b0;
          n.ovrErr = 1'b0;
        end
        default: n.rdata = 8'h00;
      endcase
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    case (r.txState)
      IDLE: begin
        n.txLine = 1'b1;
        if (tick && r.txCnt != '0 && !r.txClr) begin
          txPop     = 1'b1;
          n.txShift = r.txMem[r.txRp];
          n.txPar   = parity_bit(r.lineFmt, r.txMem[r.txRp]);                    // R05
          n.txState = START;
          n.txTick  = 6'h0;
          n.txLine  = 1'b0;
        end
      end
      START, DATA, PARITY, STOP: begin
        if (tick) begin
          n.txTick = r.txTick + 6'h1;
          if (r.txState != STOP && r.txTick == uart_line_format_pkg::TICKS_BIT - 6'h1) begin
            n.txTick = 6'h0;
            if (r.txState == START || (r.txState == DATA && r.txBit != lastBit)) begin
              n.txBit   = (r.txState == START) ? 3'h0 : r.txBit + 3'h1;
              n.txLine  = (r.txState == START) ? r.txShift[0] : r.txShift[1];
              n.txShift = (r.txState == START) ? r.txShift : r.txShift >> 1;
              n.txState = DATA;
            end else if (r.txState == DATA && r.lineFmt[uart_line_format_pkg::PAR_EN_BIT]) begin
              n.txState = PARITY;                                                // R05
              n.txLine  = r.txPar;
            end else begin
              n.txState = STOP;
              n.txLine  = 1'b1;
            end
          end else if (r.txState == STOP && r.txTick == stopTicks - 6'h1) begin
            n.txState = IDLE;                                                    // R08
          end
        end
      end
      default: n.txState = IDLE;
    endcase

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    case (r.rxState)
      IDLE: begin
        if (tick && !r.rSync2) begin
          n.rxState = START;
          n.rxTick  = 6'h0;
        end
      end
      START, DATA, PARITY, STOP: begin
        if (tick) begin
          n.rxTick = r.rxTick + 6'h1;
          if (r.rxState == START && r.rxTick == uart_line_format_pkg::TICKS_HALF - 6'h1) begin
            n.rxTick  = 6'h0;
            n.rxBit   = 3'h0;
            n.rxState = r.rSync2 ? IDLE : DATA;
          end else if (r.rxState != START
                       && r.rxTick == uart_line_format_pkg::TICKS_BIT - 6'h1) begin
            n.rxTick = 6'h0;
            if (r.rxState == DATA) begin
              n.rxShift = {r.rSync2, r.rxShift[7:1]};
              n.rxBit   = r.rxBit + 3'h1;
              if (r.rxBit == lastBit) begin                                      // R09
                n.rxState = r.lineFmt[uart_line_format_pkg::PAR_EN_BIT] ? PARITY : STOP;
              end
            end else if (r.rxState == PARITY) begin
              n.rxPar   = r.rSync2;                                              // R05
              n.rxState = STOP;
            end else begin
              n.rxState = IDLE;
              rxPush    = !r.rxClr;
              if (!r.rSync2) begin
                n.frmErr = 1'b1;
              end
              if (r.lineFmt[uart_line_format_pkg::PAR_EN_BIT]
                  && r.rxPar != parity_bit(r.lineFmt, rxWord)) begin
                n.parErr = 1'b1;                                                 // R06 R07
              end
            end
          end
        end
      end
      default: n.rxState = IDLE;
    endcase

    // ----------------------------------------------------------------
    // FIFO storage
    // ----------------------------------------------------------------
    if (txPush) begin
      n.txMem[r.txWp] = regWdata;
      n.txWp          = r.fifoEn ? PW'(r.txWp + 1'b1) : r.txWp;
    end
    if (txPop) begin
      n.txRp = r.fifoEn ? PW'(r.txRp + 1'b1) : r.txRp;
    end
    n.txCnt = r.txCnt + CW'(txPush) - CW'(txPop);
    if (rxPush && r.rxCnt >= cap) begin
      rxPush   = 1'b0;
      n.ovrErr = 1'b1;
    end
    if (rxPush) begin
      n.rxMem[r.rxWp] = rxWord;
      n.rxWp          = r.fifoEn ? PW'(r.rxWp + 1'b1) : r.rxWp;
    end
    if (rxPop) begin
      n.rxRp = r.fifoEn ? PW'(r.rxRp + 1'b1) : r.rxRp;
    end
    n.rxCnt = r.rxCnt + CW'(rxPush) - CW'(rxPop);

    // Clears wait for crystal edges; shift registers are left alone
    if (r.txClr && xRise) begin
      n.txEdges = r.txEdges + 2'h1;                                              // R02
      if (r.txEdges == uart_line_format_pkg::CLR_XTAL_EDGES - 2'h1) begin
        n.txClr = 1'b0;                                                          // R10
        n.txWp  = '0;
        n.txRp  = '0;
        n.txCnt = '0;
      end
    end
    if (r.rxClr && xRise) begin
      n.rxEdges = r.rxEdges + 2'h1;                                              // R02
      if (r.rxEdges == uart_line_format_pkg::CLR_XTAL_EDGES - 2'h1) begin
        n.rxClr = 1'b0;                                                          // R10
        n.rxWp  = '0;
        n.rxRp  = '0;
        n.rxCnt = '0;
      end
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      r         <= '0;
      r.lineFmt <= uart_line_format_pkg::LINE_FMT_RST;                           // R03
      r.divLow  <= uart_line_format_pkg::DIV_LOW_RST;
      r.divHigh <= uart_line_format_pkg::DIV_HIGH_RST;
      r.txLine  <= 1'b1;
      r.xSync1  <= 1'b0;
      r.rSync1  <= 1'b1;
      r.rSync2  <= 1'b1;
      r.txState <= IDLE;
      r.rxState <= IDLE;
    end else begin
      r <= n;
    end
  end

  // Break overrides the line from a flop of its own
  logic txOut_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      txOut_r <= 1'b1;
    end else begin
      txOut_r <= n.txLine && !n.lineFmt[uart_line_format_pkg::BREAK_BIT];        // R04
    end
  end

  assign txOut    = txOut_r;
  assign regRdata = r.rdata;

endmodule : uart_line_format_control

// ===== uart_line_format_checker.sv
`timescale 1ns/100ps
module uart_line_format_checker (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       xtalRef,
  input wire logic [3:0] regAddr,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       rxIn,
  input wire logic       txOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Shadow of written settings
  // ----------------------------------------------------------------
  logic [7:0] fmt_r;
  logic       fifoEn_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      fmt_r    <= 8'h00;
      fifoEn_r <= 1'b0;
    end else begin
      if (regWrite && regAddr == 4'h3) fmt_r <= regWdata;
      if (regWrite && regAddr == 4'h2) fifoEn_r <= regWdata[0];
    end
  end
  sequence rdAt(logic [3:0] a);
    regRead && regAddr == a;
  endsequence
  sequence brkWr;
    regWrite && regAddr == 4'h3 && regWdata[6];
  endsequence
  AST_RST_TX: assert property (disable iff (1'b0) rst |=> txOut)
    else $error("txOut not idle after reset");
  AST_RST_RDATA: assert property (disable iff (1'b0) rst |=> regRdata == 8'h00)
    else $error("read data not cleared by reset");
  AST_FMT_READ: assert property (rdAt(4'h3) |=> regRdata == $past(fmt_r))
    else $error("line format readback wrong");
  AST_RD_HOLD: assert property (!regRead |=> $stable(regRdata))
    else $error("read data changed without a read");
  AST_IDENT: assert property (rdAt(4'h2) |=> regRdata == {{2{$past(fifoEn_r)}}, 6'h01})
    else $error("fifo enable flags wrong");
  AST_DIV_GATE: assert property (rdAt(4'h1) ##0 (!fmt_r[7] || fmt_r == 8'hbf)
    |=> regRdata == 8'h00)
    else $error("divisor visible while gated");
  AST_UNMAPPED: assert property (regRead && (regAddr == 4'h4 || regAddr > 4'h5)
    |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  AST_BREAK_ON: assert property (brkWr |-> ##[1:3] !txOut)
    else $error("break not applied");
  AST_BREAK_HOLD: assert property (fmt_r[6] && $past(fmt_r[6], 2) |-> !txOut)
    else $error("line left break state");
endmodule : uart_line_format_checker

bind uart_line_format_control uart_line_format_checker chk (.mclk, .rst, .xtalRef,
  .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .rxIn, .txOut);

// ===== uart_terminal_model.sv
`timescale 1ns/100ps
module uart_terminal_model #(
  parameter int BITCYC = 16
) (
  input  wire logic       mclk,
  input  wire logic [7:0] fmt,
  input  wire logic       listen,
  input  wire logic       txLine,
  output logic            rxLine,
  output logic            got,
  output logic [7:0]      gotData,
  output logic            gotPar,
  output logic            gotStop,
  output int              gotTime
);
  int cyc;
  initial begin
    rxLine = 1'b1;
    got = 1'b0;
    cyc = 0;
  end
  always @(posedge mclk) cyc++;
  // ----------------------------------------------------------------
  // Sender: LSB first, parity bit p when enabled, one stop bit
  // ----------------------------------------------------------------
  task automatic put(input logic [7:0] d, input logic p);
    @(negedge mclk) rxLine = 1'b0;
    repeat (BITCYC) @(negedge mclk);
    for (int i = 0; i < 5 + fmt[1:0]; i++) begin
      rxLine = d[i];
      repeat (BITCYC) @(negedge mclk);
    end
    if (fmt[3]) begin
      rxLine = p;
      repeat (BITCYC) @(negedge mclk);
    end
    rxLine = 1'b1;
    repeat (BITCYC) @(negedge mclk);
  endtask : put
  // ----------------------------------------------------------------
  // Receiver: samples mid-bit, reports at mid-stop
  // ----------------------------------------------------------------
  always begin
    @(negedge txLine iff listen);
    gotTime = cyc;
    gotData = 8'h00;
    gotPar = 1'b0;
    repeat (BITCYC / 2) @(posedge mclk);
    for (int i = 0; i < 5 + fmt[1:0]; i++) begin
      repeat (BITCYC) @(posedge mclk);
      gotData[i] = txLine;
    end
    if (fmt[3]) begin
      repeat (BITCYC) @(posedge mclk);
      gotPar = txLine;
    end
    repeat (BITCYC) @(posedge mclk);
    gotStop = txLine;
    @(negedge mclk) got = 1'b1;
    @(negedge mclk) got = 1'b0;
  end
endmodule : uart_terminal_model

// ===== uart_line_format_control_bench.sv
`timescale 1ns/100ps
module uart_line_format_control_bench;
  logic        mclk = 1'b0, rst = 1'b1, xtalRef = 1'b0, xtalOn = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic        regWrite = 1'b0, regRead = 1'b0, rdPend = 1'b0, listen = 1'b1;
  logic [7:0]  regWdata = 8'h00, fmt = 8'h03, regRdata, gotData, d;
  logic        rxIn, txOut, got, gotPar, gotStop;
  logic [16:0] e;
  logic [2:0]  pm[5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
  int          gotTime, lastTime, expLen = 0, err_count = 0, check_count = 0;
  logic [7:0]  rdq[$];
  logic [16:0] txq[$];
  always #12.5 mclk = ~mclk;
  always #35 if (xtalOn) xtalRef = ~xtalRef;
  uart_line_format_control #(.DEPTH(4)) uut (.mclk, .rst, .xtalRef, .regAddr, .regWrite,
    .regRead, .regWdata, .regRdata, .rxIn, .txOut);
  uart_terminal_model tp (.mclk, .fmt, .listen, .txLine(txOut), .rxLine(rxIn), .got,
    .gotData, .gotPar, .gotStop, .gotTime);
  task automatic check(input logic [16:0] a, b, input string s);
    check_count++;
    if (a !== b) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, s, a, b);
    end
  endtask : check
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
    if (!w) rdq.push_back(v);
    @(negedge mclk);
    regAddr = a;
    regWdata = v;
    regWrite = w;
    regRead = !w;
    @(negedge mclk);
    regWrite = 1'b0;
    regRead = 1'b0;
  endtask : acc
  function automatic logic par(input logic [7:0] v, input logic [7:0] f);
    return f[5] ? !f[4] : (^v) ^ !f[4];
  endfunction : par
  function automatic logic [7:0] flen(input logic [7:0] f);
    return 8'((6 + f[1:0] + f[3]) * 16 + (f[2] ? (f[1:0] == 0 ? 24 : 32) : 16));
  endfunction : flen
  // ----------------------------------------------------------------
  // Monitors: oldest note against each result
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rdPend) check(regRdata, rdq.pop_front(), "read");
    rdPend <= regRead;
    if (got) begin
      e = txq.pop_front();
      check({gotData, gotPar, gotStop}, {e[16:8], 1'b1}, "frame");
      if (expLen != 0) check(17'(gotTime - lastTime - expLen) <= 17'h1, 1'b1, "spacing");
      expLen = e[7:0];
      lastTime = gotTime;
    end
  end
  initial begin
    #2000000;
    err_count++;
    end_sim();
  end
  initial begin
    void'($urandom(20));
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    acc(0, 4'h3, 8'h00);
    acc(0, 4'h2, 8'h01);
    acc(0, 4'h5, 8'h60);
    acc(0, 4'h9, 8'h00);
    acc(1, 4'h3, 8'h80);
    acc(0, 4'h0, 8'h01);
    acc(1, 4'h0, 8'h5a);
    acc(0, 4'h0, 8'h5a);
    acc(1, 4'h3, 8'hbf);
    acc(0, 4'h0, 8'h00);
    acc(0, 4'h1, 8'h00);
    acc(1, 4'h0, 8'h33);
    acc(1, 4'h3, 8'h80);
    acc(0, 4'h0, 8'h5a);
    acc(1, 4'h0, 8'h01);
    acc(1, 4'h3, 8'h03);
    acc(0, 4'h1, 8'h00);
    acc(1, 4'h2, 8'h01);
    acc(0, 4'h2, 8'hc1);
    $display("registers test done");
    for (int m = 0; m < 40; m++) begin
      fmt = {2'b00, pm[m % 5], 1'(m / 5 % 2), 2'(m / 10)};
      acc(1, 4'h3, fmt);
      for (int k = 0; k < 2; k++) begin
        d = 8'($urandom) & (8'hff >> (3 - fmt[1:0]));
        txq.push_back({d, fmt[3] & par(d, fmt), k ? 8'h00 : flen(fmt)});
        acc(1, 4'h0, d);
      end
      for (int t = 0; t < 1000 && txq.size() != 0; t++) @(negedge mclk);
      repeat (40) @(negedge mclk);
    end
    check(17'(txq.size()), 17'h0, "frames missing");
    $display("transmit format test done");
    listen = 1'b0;
    acc(1, 4'h3, 8'h43);
    repeat (100) @(negedge mclk);
    check(txOut, 1'b0, "break");
    acc(1, 4'h3, 8'h03);
    repeat (4) @(negedge mclk);
    check(txOut, 1'b1, "break end");
    listen = 1'b1;
    $display("break test done");
    for (int m = 0; m < 8; m++) begin
      fmt = {2'b00, pm[1 + m % 4], 1'b0, 2'(m % 4)};
      acc(1, 4'h3, fmt);
      d = 8'($urandom) & (8'hff >> (3 - fmt[1:0]));
      tp.put(d, par(d, fmt) ^ m[2]);
      repeat (4) @(negedge mclk);
      acc(0, 4'h5, m[2] ? 8'h65 : 8'h61);
      acc(0, 4'h0, d);
    end
    $display("receive format test done");
    fmt = 8'h03;
    acc(1, 4'h3, fmt);
    for (int j = 0; j < 2; j++) begin
      acc(1, 4'h2, 8'(j));
      for (int k = 0; k < 5; k++) tp.put(8'(k + 16 * j), 1'b0);
      repeat (4) @(negedge mclk);
      acc(0, 4'h5, 8'h63);
      for (int k = 0; k < (j ? 4 : 1); k++) acc(0, 4'h0, 8'(k + 16 * j));
      acc(0, 4'h5, 8'h60);
    end
    tp.put(8'h77, 1'b0);
    acc(1, 4'h2, 8'h07);
    acc(1, 4'h0, 8'h55);
    repeat (50) @(negedge mclk);
    acc(0, 4'h5, 8'h01);
    xtalOn = 1'b1;
    repeat (40) @(negedge mclk);
    acc(0, 4'h5, 8'h60);
    acc(0, 4'h2, 8'hc1);
    xtalOn = 1'b0;
    repeat (4) @(negedge mclk);
    $display("fifo test done");
    end_sim();
  end
endmodule : uart_line_format_control_bench
